// [hdl/nvmc_pkg.sv]
package nvmc_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int unsigned   WORD_W        = 16;
	localparam int unsigned   ARRAY_BYTES   = 98304;
	localparam int unsigned   KERNEL_BYTES  = 2048;
	localparam int unsigned   PAGE_BYTES    = 512;
	localparam int unsigned   PAGE_WORDS    = PAGE_BYTES / 2;
	localparam int unsigned   ADDR_W        = 20;
	localparam logic [19:0]   PHYS_BASE     = 20'h80000;
	localparam logic [19:0]   MIRROR_BASE   = 20'h00000;
	localparam logic [19:0]   BLK0_LO       = 20'h90000;
	localparam logic [19:0]   BLK0_HI       = 20'h97FFF;
	localparam logic [19:0]   BLK1_LO       = 20'h80000;
	localparam logic [19:0]   BLK1_HI       = 20'h8FFFF;
	localparam logic [19:0]   KERNEL_LO     = 20'h97800;
	localparam logic [15:0]   ERASED_WORD   = 16'hFFFF;

	// Block words (block 1 modelled 64 kB, block 0 32 kB)
	localparam int unsigned   BLK0_WORDS    = 16384;
	localparam int unsigned   BLK1_WORDS    = 32768;

	// ----------------------------------------------------------------
	// Timing, in 40 MHz clock cycles counted only while the clock enable is high, so a core divider stretches it
	// ----------------------------------------------------------------
	localparam int unsigned   CLK_HZ        = 40000000;
	localparam int unsigned   ERASE_MS      = 20;
	localparam int unsigned   PROG_US       = 50;
	localparam int unsigned   MASS_MS       = 1200;
	localparam int unsigned   ERASE_CYC     = ERASE_MS * (CLK_HZ / 1000);
	localparam int unsigned   PROG_CYC      = PROG_US * (CLK_HZ / 1000000);
	localparam int unsigned   MASS_CYC      = MASS_MS * (CLK_HZ / 1000);
	localparam int unsigned   TMR_W         = 26;

	// ----------------------------------------------------------------
	// Commands and status
	// ----------------------------------------------------------------
	typedef enum logic [7:0]
	{
		NVMC_CMD_READ    = 8'h01,
		NVMC_CMD_PROG    = 8'h02,
		NVMC_CMD_ERPROG  = 8'h03,
		NVMC_CMD_VERIFY  = 8'h04,
		NVMC_CMD_ERASE   = 8'h05,
		NVMC_CMD_MASS    = 8'h06,
		NVMC_CMD_IDLE    = 8'h07,
		NVMC_CMD_SIGN    = 8'h0B,
		NVMC_CMD_PROTECT = 8'h0C
	} nvmc_cmd_e;

	localparam logic [7:0]    CMD_RESET     = 8'h07;
	localparam logic [23:0]   SIG_SEED      = 24'hFFFFFF;
	localparam logic [23:0]   SIG_POLY      = 24'h80000D;
	localparam logic [15:0]   PROT_OPEN     = 16'h0000;
	localparam logic [7:0]    MODE_RESET    = 8'h00;
	localparam int unsigned   MODE_WEN_BIT  = 3;

	// Status word of one block
	typedef struct packed
	{
		logic       protect_err;
		logic       busy;
		logic       verify_fail;
		logic       done;
	} nvmc_status_s;

	// Register write port of one block
	typedef struct packed
	{
		logic        cmd_we;
		logic [7:0]  cmd;
		logic        mode_we;
		logic [7:0]  mode;
		logic        data_we;
		logic [15:0] data;
		logic        addr_we;
		logic [15:0] addr;
		logic        prot_we;
		logic [15:0] prot;
		logic        key_we;
		logic [15:0] key;
	} nvmc_regwr_s;

	// Register readback of one block
	typedef struct packed
	{
		nvmc_status_s status;
		logic [7:0]   mode;
		logic [7:0]   cmd;
		logic [15:0]  data;
		logic [15:0]  addr;
		logic [23:0]  signature;
		logic [15:0]  protection;
		logic [15:0]  prot_buffer;
	} nvmc_regrd_s;

	// Erased word, two lanes of 0xFF
	function automatic logic [15:0] erased();
		return ERASED_WORD;
	endfunction

	// One LFSR step folding in a data word
	function automatic logic [23:0] sig_step(input logic [23:0] s, input logic [15:0] d);
		logic [23:0] n;
		n = {s[22:0], 1'b0} ^ (s[23] ? SIG_POLY : 24'h000000);
		return n ^ {8'h00, d};
	endfunction

endpackage

// [hdl/nvmc_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module nvmc_timer
(
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_enable,
	// Control
	input  wire logic                   i_start,
	input  wire logic [25:0]            i_cycles,
	// Status
	output logic                        o_busy,
	output logic                        o_done
);

	logic [25:0] count;

	// Counts only on clock edges with i_enable high, so holding i_enable low stretches it
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count <= 26'h0000000;
		else if (i_enable)
		begin
			if (i_start)
				count <= i_cycles;
			else if (count != 26'h0000000)
				count <= count - 26'h0000001;
		end
	end

	assign o_busy = (count != 26'h0000000);
	// Last counted cycle; the sequencer leaves its wait on this edge, so busy is exact
	assign o_done = (count == 26'h0000001);

endmodule

`default_nettype wire

// [hdl/nvmc_block.sv]
`timescale 1ns/1ps
`default_nettype none

module nvmc_block
#(
	parameter int unsigned      WORDS    = 16384,
	parameter logic [19:0]      BASE     = 20'h90000,
	parameter int unsigned      AW       = 14,
	parameter logic [25:0]      ERASE_T  = 26'd800000,
	parameter logic [25:0]      PROG_T   = 26'd2000,
	parameter logic [25:0]      MASS_T   = 26'd48000000
)
(
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_enable,
	// Registers
	input  wire nvmc_pkg::nvmc_regwr_s  i_wr,
	output nvmc_pkg::nvmc_regrd_s       o_rd,
	// Fetch port, two halfwords per access
	input  wire logic [AW-1:0]          i_fetch_word,
	output logic [31:0]                 o_fetch_data,
	output logic                        o_busy
);

	typedef enum logic [2:0]
	{
		NVMC_ST_IDLE  = 3'b000,
		NVMC_ST_WAIT  = 3'b001,
		NVMC_ST_ERASE = 3'b010,
		NVMC_ST_SIGN  = 3'b011
	} nvmc_state_e;

	logic [15:0]   mem [0:WORDS-1];
	nvmc_state_e   state;
	logic [7:0]    cmd;
	logic [7:0]    mode;
	logic [15:0]   data;
	logic [15:0]   addr;
	logic [23:0]   sig;
	logic [15:0]   prot;
	logic [15:0]   prot_buf;
	logic          prot_stored;
	logic          done;
	logic          vfail;
	logic          perr;
	logic          prog_after;
	logic [AW-1:0] walk;
	logic [AW-1:0] walk_end;
	logic          t_start;
	logic [25:0]   t_cycles;
	logic          t_busy;
	logic          t_done;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire [AW-1:0] word_ix  = addr[AW:1];
	wire [AW-1:0] page_lo  = {word_ix[AW-1:8], 8'h00};
	wire          writable = mode[nvmc_pkg::MODE_WEN_BIT] && (prot == nvmc_pkg::PROT_OPEN);
	wire          go       = i_wr.cmd_we && (state == NVMC_ST_IDLE);
	wire          is_prog  = (i_wr.cmd == nvmc_pkg::NVMC_CMD_PROG);
	wire          is_erase = (i_wr.cmd == nvmc_pkg::NVMC_CMD_ERASE)
	                         || (i_wr.cmd == nvmc_pkg::NVMC_CMD_ERPROG);
	wire          is_mass  = (i_wr.cmd == nvmc_pkg::NVMC_CMD_MASS);
	wire          timed    = is_prog || is_erase || is_mass;

	assign t_start  = i_enable && go && timed && writable;
	assign t_cycles = is_prog ? PROG_T : (is_mass ? MASS_T : ERASE_T);

	nvmc_timer u_timer
	(
		.i_clock  (i_clock),
		.i_rst_n  (i_rst_n),
		.i_enable (i_enable),
		.i_start  (t_start),
		.i_cycles (t_cycles),
		.o_busy   (t_busy),
		.o_done   (t_done)
	);

	// Array contents; erased state reads as all ones
	always_ff @(posedge i_clock)
	begin
		if (i_enable && (state == NVMC_ST_ERASE))
			mem[walk] <= nvmc_pkg::erased();
		else if (i_enable && go && is_prog && writable)
			mem[word_ix] <= mem[word_ix] & data;
		else if (i_enable && (state == NVMC_ST_WAIT) && t_done && prog_after)
			mem[word_ix] <= data;
	end

	// Both halfwords fetched together in one cycle
	always_ff @(posedge i_clock)
	begin
		if (i_enable)
			o_fetch_data <= {mem[i_fetch_word + AW'(1)], mem[i_fetch_word]};
	end

	// Command sequencer and register file
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= NVMC_ST_IDLE;
			cmd <= nvmc_pkg::CMD_RESET;
			mode <= nvmc_pkg::MODE_RESET;
			data <= 16'h0000;
			addr <= 16'h0000;
			sig <= 24'h000000;
			prot <= 16'h0000;
			done <= 1'b0;
			vfail <= 1'b0;
			perr <= 1'b0;
			prog_after <= 1'b0;
			walk <= '0;
			walk_end <= '0;
		end
		else if (i_enable)
		begin
			if (i_wr.mode_we)
				mode <= i_wr.mode;
			if (i_wr.data_we && state == NVMC_ST_IDLE)
				data <= i_wr.data;
			if (i_wr.addr_we && state == NVMC_ST_IDLE)
				addr <= i_wr.addr;
			if (i_wr.key_we && (i_wr.key == prot_buf))
				prot <= nvmc_pkg::PROT_OPEN;
			else if (i_wr.prot_we && !prot_stored)
				prot <= i_wr.prot;
			if (go)
			begin
				cmd <= i_wr.cmd;
				done <= 1'b0;
				perr <= timed && !writable;
				prog_after <= (i_wr.cmd == nvmc_pkg::NVMC_CMD_ERPROG);
				case (i_wr.cmd)
					nvmc_pkg::NVMC_CMD_READ:
					begin
						data <= mem[word_ix];
						done <= 1'b1;
					end
					nvmc_pkg::NVMC_CMD_VERIFY:
					begin
						vfail <= (mem[word_ix] != data);
						done <= 1'b1;
					end
					nvmc_pkg::NVMC_CMD_SIGN:
					begin
						sig <= nvmc_pkg::SIG_SEED;
						walk <= word_ix;
						state <= NVMC_ST_SIGN;
					end
					default:
					begin
						if (timed && writable)
						begin
							walk <= is_mass ? '0 : page_lo;
							walk_end <= is_mass ? AW'(WORDS-1) : page_lo + AW'(255);
							state <= is_prog ? NVMC_ST_WAIT : NVMC_ST_ERASE;
						end
						else
							done <= 1'b1;
					end
				endcase
			end
			else
			begin
				case (state)
					NVMC_ST_ERASE:
					begin
						walk <= walk + AW'(1);
						if (walk == walk_end)
							state <= NVMC_ST_WAIT;
					end
					NVMC_ST_WAIT:
						if (t_done)
						begin
							state <= NVMC_ST_IDLE;
							done <= 1'b1;
						end
					NVMC_ST_SIGN:
					begin
						sig <= nvmc_pkg::sig_step(sig, mem[walk]);
						walk <= walk + AW'(1);
						if (walk == AW'(WORDS-1))
						begin
							state <= NVMC_ST_IDLE;
							done <= 1'b1;
						end
					end
					default:
						state <= NVMC_ST_IDLE;
				endcase
			end
		end
	end

	// Stored protection copy cleared to open at every reset
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			prot_buf <= nvmc_pkg::PROT_OPEN;
			prot_stored <= 1'b0;
		end
		else if (i_enable && go && (i_wr.cmd == nvmc_pkg::NVMC_CMD_PROTECT) && !prot_stored)
		begin
			prot_buf <= prot;
			prot_stored <= 1'b1;
		end
		else if (i_enable && go && is_mass && writable)
			prot_stored <= 1'b0;
	end

	assign o_busy = (state != NVMC_ST_IDLE) || t_busy;

	// Status mirrors the control interface
	assign o_rd.status      = '{protect_err: perr, busy: o_busy, verify_fail: vfail, done: done};
	assign o_rd.mode        = mode;
	assign o_rd.cmd         = cmd;
	assign o_rd.data        = data;
	assign o_rd.addr        = addr;
	assign o_rd.signature   = sig;
	assign o_rd.protection  = prot;
	assign o_rd.prot_buffer = prot_buf;

endmodule

`default_nettype wire

// [hdl/nvmc_top.sv]
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - 96 kB array of 16-bit words, 2 kB kernel
// - Erase works on whole 512-byte pages
// - Page erase 20 ms, word program 50 us
// - Timings fixed, independent of core divider; here the timer counts only cycles with i_clk_en high
// - 32-bit fetch returns two halfwords together
// - Array at 0x80000, mirrored at zero
// - Erased locations read all ones
// - Reads of 8/16/32 bits; program 16 only
// - Block 0 spans 0x90000 to 0x97FFF
// - Block 1 spans 0x80000 to 0x8FFFF, own registers
// - Other block fetches run during commands
// - Fetch from busy block stalls core
// - Read-only status register per block
// - Mode register per block
// - Eight-bit command register starts operations
// - Sixteen-bit data and address registers
// - Signature command yields 24-bit signature
// - Protection register gates access, key unlocks
// - Protection and its buffer both clear to open at reset
// - Command codes 01 to 06, 07 idle
module nvmc_top
(
	// Clock, reset, enable
	input  wire logic                   i_clock,
	input  wire logic                   i_arst_n,
	input  wire logic                   i_clk_en,
	// Register ports of the two blocks
	input  wire nvmc_pkg::nvmc_regwr_s  i_blk0_wr,
	input  wire nvmc_pkg::nvmc_regwr_s  i_blk1_wr,
	output nvmc_pkg::nvmc_regrd_s       o_blk0_rd,
	output nvmc_pkg::nvmc_regrd_s       o_blk1_rd,
	// Core read port
	input  wire logic                   i_rd_req,
	input  wire logic [31:0]            i_rd_addr,
	input  wire logic [1:0]             i_rd_size,
	input  wire logic                   i_remap_sram,
	output logic                        o_rd_ack,
	output logic [31:0]                 o_rd_data,
	output logic                        o_rd_err,
	output logic                        o_stall
);

	logic        rst_meta;
	logic        rst_n;
	logic [31:0] f0_data;
	logic [31:0] f1_data;
	logic        busy0;
	logic        busy1;
	logic        sel0_q;
	logic [1:0]  lane_q;
	logic [1:0]  size_q;
	logic        ack;
	logic        err;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Mirror at zero unless SRAM is remapped; remap input clears with reset upstream
	wire        mirror = !i_remap_sram && (i_rd_addr[31:20] == 12'h000)
	                     && (i_rd_addr[19:0] < 20'(nvmc_pkg::ARRAY_BYTES));
	wire [19:0] a_phys = mirror ? (i_rd_addr[19:0] + nvmc_pkg::PHYS_BASE) : i_rd_addr[19:0];
	wire        a_top  = (i_rd_addr[31:20] == 12'h000);
	wire        hit0   = a_top && (a_phys >= nvmc_pkg::BLK0_LO)
	                     && (a_phys <= nvmc_pkg::BLK0_HI);
	wire        hit1   = a_top && (a_phys >= nvmc_pkg::BLK1_LO)
	                     && (a_phys <= nvmc_pkg::BLK1_HI);
	wire        hit    = (hit0 || hit1) && (mirror || (i_rd_addr[19:0] >= nvmc_pkg::PHYS_BASE));
	wire        kern   = hit0 && (a_phys >= nvmc_pkg::KERNEL_LO);
	// Only the addressed block stalls; the other keeps serving
	wire        blk_busy = hit0 ? busy0 : busy1;
	// Unmapped requests never wait on a block, so they are refused at once
	wire        take     = i_rd_req && i_clk_en && !(hit && blk_busy);
	wire [13:0] w0 = 14'(a_phys[15:1] & 15'h3FFE);
	wire [14:0] w1 = 15'(a_phys[16:1] & 16'hFFFE);

	assign o_stall = i_rd_req && hit && blk_busy;

	nvmc_block
	#(
		.WORDS   (nvmc_pkg::BLK0_WORDS),
		.BASE    (nvmc_pkg::BLK0_LO),
		.AW      (14),
		.ERASE_T (26'(nvmc_pkg::ERASE_CYC)),
		.PROG_T  (26'(nvmc_pkg::PROG_CYC)),
		.MASS_T  (26'(nvmc_pkg::MASS_CYC))
	)
	u_blk0
	(
		.i_clock      (i_clock),
		.i_rst_n      (rst_n),
		.i_enable     (i_clk_en),
		.i_wr         (i_blk0_wr),
		.o_rd         (o_blk0_rd),
		.i_fetch_word (w0),
		.o_fetch_data (f0_data),
		.o_busy       (busy0)
	);

	nvmc_block
	#(
		.WORDS   (nvmc_pkg::BLK1_WORDS),
		.BASE    (nvmc_pkg::BLK1_LO),
		.AW      (15),
		.ERASE_T (26'(nvmc_pkg::ERASE_CYC)),
		.PROG_T  (26'(nvmc_pkg::PROG_CYC)),
		.MASS_T  (26'(nvmc_pkg::MASS_CYC))
	)
	u_blk1
	(
		.i_clock      (i_clock),
		.i_rst_n      (rst_n),
		.i_enable     (i_clk_en),
		.i_wr         (i_blk1_wr),
		.o_rd         (o_blk1_rd),
		.i_fetch_word (w1),
		.o_fetch_data (f1_data),
		.o_busy       (busy1)
	);

	// ----------------------------------------------------------------
	// Read response, one cycle after acceptance
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack <= 1'b0;
			err <= 1'b0;
			sel0_q <= 1'b0;
			lane_q <= 2'h0;
			size_q <= 2'h0;
		end
		else if (i_clk_en)
		begin
			ack <= take && hit && !kern;
			err <= take && (!hit || kern);
			sel0_q <= hit0;
			lane_q <= a_phys[1:0];
			size_q <= i_rd_size;
		end
	end

	// Byte, halfword or word out of the paired fetch
	wire [31:0] word = sel0_q ? f0_data : f1_data;
	wire [31:0] shft = word >> {lane_q, 3'b000};

	always_comb
	begin
		case (size_q)
			2'h0:    o_rd_data = {24'h000000, shft[7:0]};
			2'h1:    o_rd_data = {16'h0000, shft[15:0]};
			default: o_rd_data = word;
		endcase
	end

	assign o_rd_ack = ack;
	assign o_rd_err = err;

endmodule

`default_nettype wire

// [tb/nvmc_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module nvmc_checker
(
	// Clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_arst_n,
	input  wire logic                  i_clk_en,
	// Register ports
	input  wire nvmc_pkg::nvmc_regwr_s i_blk1_wr,
	input  wire nvmc_pkg::nvmc_regrd_s o_blk0_rd,
	input  wire nvmc_pkg::nvmc_regrd_s o_blk1_rd,
	// Core read port
	input  wire logic                  i_rd_req,
	input  wire logic [31:0]           i_rd_addr,
	input  wire logic                  o_rd_ack,
	input  wire logic                  o_rd_err,
	input  wire logic                  o_stall
);
	// ----------------
	// Helper logic
	// ----------------
	logic [1:0] age;
	logic       ready;
	logic       b1;
	logic       go1;

	// Requests count only once the reset synchroniser has drained
	assign ready = (age == 2'h3) && i_clk_en;
	assign b1    = o_blk1_rd.status.busy;
	assign go1   = ready && i_blk1_wr.cmd_we && !b1;

	// Edges since reset release, saturating
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	end

	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	// ----------------
	// Properties
	// ----------------
	chk_cmd_idle: assert property ($rose(i_arst_n) |-> o_blk1_rd.cmd == 8'h07)
		else $error("command not idle after reset");
	chk_prog_busy: assert property (go1 && i_blk1_wr.cmd == 8'h02 && o_blk1_rd.mode[3]
		&& o_blk1_rd.protection == 16'h0000 |=> b1) else $error("program did not go busy");
	chk_refused_prog: assert property (go1 && i_blk1_wr.cmd == 8'h02 && !o_blk1_rd.mode[3]
		|=> o_blk1_rd.status.protect_err && o_blk1_rd.status.done && !b1)
		else $error("locked program not refused");
	chk_read_done: assert property (go1 && i_blk1_wr.cmd == 8'h01 |=> o_blk1_rd.status.done && !b1)
		else $error("read command not done next cycle");
	chk_busy_length: assert property ($rose(b1) |-> b1[*8])
		else $error("timed operation too short");
	chk_done_fall: assert property ($fell(b1) |-> o_blk1_rd.status.done)
		else $error("busy ended without done");
	chk_cmd_hold: assert property (ready && b1 && i_blk1_wr.cmd_we |=> $stable(o_blk1_rd.cmd))
		else $error("command taken while busy");
	chk_stall_hit: assert property (i_rd_req && i_rd_addr[31:16] == 16'h0008 && b1 |-> o_stall)
		else $error("fetch from busy block not stalled");
	chk_other_free: assert property (i_rd_req && i_rd_addr[31:16] == 16'h0009
		&& !o_blk0_rd.status.busy |-> !o_stall) else $error("idle block fetch stalled");
	chk_one_answer: assert property (ready && i_rd_req && !o_stall |=> o_rd_ack != o_rd_err)
		else $error("fetch not answered once");
	chk_stall_quiet: assert property (ready && o_stall |=> !o_rd_ack && !o_rd_err)
		else $error("stalled fetch answered");

	// Main scenarios reached
	cover property (o_stall);
	cover property ($fell(b1));
	cover property (o_rd_err);
endmodule

bind nvmc_top nvmc_checker u_chk
(
	.i_clock, .i_arst_n, .i_clk_en, .i_blk1_wr, .o_blk0_rd, .o_blk1_rd,
	.i_rd_req, .i_rd_addr, .o_rd_ack, .o_rd_err, .o_stall
);

`default_nettype wire

// [tb/nvmc_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module nvmc_core_model
(
	// Clock
	input  wire logic        i_clock,
	// Core read port
	output logic             o_rd_req,
	output logic [31:0]      o_rd_addr,
	output logic [1:0]       o_rd_size,
	input  wire logic        i_stall
);
	// Idle bus never shows a stale address
	initial
	begin
		o_rd_req  = 1'b0;
		o_rd_addr = 32'h5A5A5A5A;
		o_rd_size = 2'h0;
	end

	// One read held while stalled, dropped after the taking edge
	// Assumes the clock enable stays high while a read is open
	task automatic fetch(input logic [31:0] a, input logic [1:0] s, output logic ok,
		output logic stalled);
		logic st;
		ok = 1'b0;
		stalled = 1'b0;
		o_rd_req = 1'b1;
		o_rd_addr = a;
		o_rd_size = s;
		for (int n = 0; n < 4000 && !ok; n++)
		begin
			// Stall has settled by the falling edge; reading it earlier races the request
			@(negedge i_clock);
			st = (i_stall === 1'b1);
			stalled = stalled | st;
			@(posedge i_clock);
			#2;
			ok = !st;
		end
		o_rd_req = 1'b0;
		o_rd_addr = ~a;
		o_rd_size = ~s;
		// One idle edge between reads, so the answer is out before the next request
		@(posedge i_clock);
		#2;
	endtask
endmodule

`default_nettype wire

// [tb/tb_nvmc_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_nvmc_top;
	// Expected answer of one core read
	typedef struct packed
	{
		logic        err;
		logic [31:0] mask;
		logic [31:0] data;
	} nvmc_exp_s;

	logic                  clock;
	logic                  arst_n;
	logic                  clk_en;
	logic                  remap;
	nvmc_pkg::nvmc_regwr_s wr [2];
	nvmc_pkg::nvmc_regrd_s rd [2];
	logic                  req;
	logic [31:0]           addr;
	logic [1:0]            size;
	logic                  ack;
	logic [31:0]           rdata;
	logic                  err;
	logic                  stall;
	nvmc_exp_s             expq [$];
	nvmc_exp_s             cur;
	int                    bad_count;
	int                    checks;
	int                    n;
	logic [15:0]           base;
	logic                  ok;
	logic                  st;
	logic [31:0]           want;
	logic [7:0]            timed [4] = '{8'h02, 8'h03, 8'h05, 8'h06};

	nvmc_top dut (.i_clock(clock), .i_arst_n(arst_n), .i_clk_en(clk_en),
		.i_blk0_wr(wr[0]), .i_blk1_wr(wr[1]), .o_blk0_rd(rd[0]), .o_blk1_rd(rd[1]),
		.i_rd_req(req), .i_rd_addr(addr), .i_rd_size(size), .i_remap_sram(remap),
		.o_rd_ack(ack), .o_rd_data(rdata), .o_rd_err(err), .o_stall(stall));
	nvmc_core_model core (.i_clock(clock), .o_rd_req(req), .o_rd_addr(addr),
		.o_rd_size(size), .i_stall(stall));

	// ----------------
	// Shared tasks
	// ----------------
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic hang();
		bad_count++;
		give_verdict();
	endtask

	// Inputs change 2 ns after the edge so the design never races the bench
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#2;
	endtask

	// Operands and mode in one cycle, the command code in the next
	task automatic op(input bit b, input logic [15:0] a, input logic [15:0] d,
		input logic [7:0] m, input logic [7:0] c);
		// Leave an edge after any earlier release of the strobes
		tick(1);
		wr[b] = '{addr_we:1'b1, addr:a, data_we:1'b1, data:d, mode_we:1'b1, mode:m, default:'0};
		tick(1);
		wr[b] = '{cmd_we:1'b1, cmd:c, default:'0};
		tick(1);
		wr[b] = '0;
	endtask

	// Bounded wait for the end of a timed operation
	task automatic await(input bit b, output int k);
		for (k = 0; k < 3000 && rd[b].status.busy === 1'b1; k++)
			tick(1);
		if (k >= 3000)
			hang();
	endtask

	// Note the expected answer, then let the core model issue the read
	task automatic fetch(input logic [31:0] a, input logic [1:0] s, input logic e,
		input logic [31:0] m);
		expq.push_back('{e, m, m & want});
		core.fetch(a, s, ok, st);
		if (ok !== 1'b1)
			hang();
	endtask

	// Each answer on the core port retires the oldest note
	always @(posedge clock)
	begin
		if (ack === 1'b1 || err === 1'b1)
		begin
			cur = expq.pop_front();
			check(32'(err), 32'(cur.err));
			check(rdata & cur.mask, cur.data);
		end
	end

	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		remap = 1'b0;
		wr[0] = '0;
		wr[1] = '0;
		bad_count = 0;
		checks = 0;
		want = '0;
		n = $urandom(32'h430A4846);
		base = {14'($urandom_range(0, 16383)), 2'h0};
		tick(20);
		arst_n = 1'b1;
		tick(3);
		check(32'(rd[1].cmd), 32'h7);
		check(32'(rd[1].protection), 32'(rd[1].prot_buffer));
		// Every timed code is refused while writes are disabled
		foreach (timed[i])
		begin
			op(1'b1, base, 16'h0000, 8'h00, timed[i]);
			check(32'(rd[1].status), 32'h9);
		end
		// Each word programmed once only between erases
		op(1'b1, base, 16'h0000, 8'h08, 8'h02);
		check(32'(rd[1].status), 32'h4);
		fork
			await(1'b1, n);
			begin
				fetch(32'h00090000, 2'h2, 1'b0, 32'h0);
				check(32'(st), 32'h0);
				wr[1] = '{cmd_we:1'b1, cmd:8'h01, default:'0};
				tick(1);
				wr[1] = '0;
				check(32'(rd[1].cmd), 32'h2);
				fetch(32'h00080000 + 32'(base), 2'h1, 1'b0, 32'h0000FFFF);
				check(32'(st), 32'h1);
			end
		join
		check(32'(n), nvmc_pkg::PROG_CYC);
		op(1'b1, base + 16'h2, 16'h0000, 8'h08, 8'h02);
		await(1'b1, n);
		check(32'(rd[1].status), 32'h1);
		// Core reads of every width, the mirror and refused places
		fetch(32'h00080000 + 32'(base), 2'h2, 1'b0, 32'hFFFFFFFF);
		fetch(32'(base), 2'h1, 1'b0, 32'h0000FFFF);
		fetch(32'h00080001 + 32'(base), 2'h0, 1'b0, 32'h0000FFFF);
		fetch(32'h00097800, 2'h1, 1'b1, 32'h0);
		fetch(32'h00070000, 2'h2, 1'b1, 32'h0);
		remap = 1'b1;
		fetch(32'(base), 2'h1, 1'b1, 32'h0);
		remap = 1'b0;
		// Read and verify through the registers
		op(1'b1, base, 16'hFFFF, 8'h08, 8'h01);
		check(32'(rd[1].data), 32'h0);
		op(1'b1, base, 16'h0000, 8'h08, 8'h04);
		check(32'(rd[1].status), 32'h1);
		op(1'b1, base, 16'h0001, 8'h08, 8'h04);
		check(32'(rd[1].status), 32'h3);
		// Clock stopped only once nothing is in flight
		clk_en = 1'b0;
		wr[1] = '{cmd_we:1'b1, cmd:8'h01, default:'0};
		tick(1);
		wr[1] = '0;
		clk_en = 1'b1;
		check(32'(rd[1].cmd), 32'h4);
		// Long erase on block 0; block 1 keeps serving fetches
		op(1'b0, 16'h0200, 16'h0000, 8'h08, 8'h05);
		check(32'(rd[0].status), 32'h4);
		fetch(32'h00080000 + 32'(base), 2'h2, 1'b0, 32'hFFFFFFFF);
		check(32'(st), 32'h0);
		// Page walk ends long before the timer, so the cut erase leaves the page blank
		tick(260);
		// A second reset aborts the erase; the array keeps its contents
		arst_n = 1'b0;
		tick(2);
		arst_n = 1'b1;
		tick(3);
		check(32'(rd[0].status), 32'h0);
		check(32'(rd[0].cmd), 32'h7);
		fetch(32'h00080000 + 32'(base), 2'h2, 1'b0, 32'hFFFFFFFF);
		want = {nvmc_pkg::ERASED_WORD, nvmc_pkg::ERASED_WORD};
		fetch(32'h00090200, 2'h2, 1'b0, 32'hFFFFFFFF);
		want = '0;
		tick(2);
		check(32'(expq.size()), 32'h0);
		give_verdict();
	end
endmodule

`default_nettype wire
